// file: shared/dcem_pkg.sv
// Constants shared by the channel event map: register map, field layout, resets
package dcem_pkg;
    localparam int CHANNELS = 64;
    localparam int CH_W = 6;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // Register byte offsets
    localparam logic [11:0] OFF_PEND_LO = 12'h000;
    localparam logic [11:0] OFF_PEND_HI = 12'h004;
    localparam logic [11:0] OFF_EN_LO = 12'h008;
    localparam logic [11:0] OFF_EN_HI = 12'h00C;
    localparam logic [11:0] OFF_SET_LO = 12'h010;
    localparam logic [11:0] OFF_SET_HI = 12'h014;
    localparam logic [11:0] OFF_IRQ_STS = 12'h018;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h01C;
    localparam logic [11:0] OFF_STATE = 12'h020;
    localparam logic [11:0] OFF_PARAM_BASE = 12'h100;
    localparam logic [11:0] OFF_PARAM_LAST = 12'h1FC;
    // Interrupt status fields
    localparam int STS_W = 2;
    localparam int STS_OVERRUN = 0;
    localparam int STS_ISSUED = 1;
    // State register fields
    localparam int ST_BUSCELL = 0;
    localparam int ST_COPROC = 1;
    localparam int ST_TVALID = 2;
    localparam int ST_TCHAN_LSB = 8;
    // Fixed channel numbers of the event map
    localparam int CH_HOST = 0;
    localparam int CH_TMR0 = 1;
    localparam int CH_TMR1 = 2;
    localparam int CH_WIDE_REF = 3;
    localparam int CH_PIN4 = 4;
    localparam int CH_PIN0 = 8;
    localparam int CH_SER0_TX = 12;
    localparam int CH_SER0_RX = 13;
    localparam int CH_SER1_TX = 14;
    localparam int CH_SER1_RX = 15;
    localparam int CH_SER2_TX = 17;
    localparam int CH_SER2_RX = 18;
    localparam int CH_TMR2 = 19;
    localparam int CH_NARROW_REF = 20;
    localparam int CH_RESERVED = 21;
    localparam int CH_VIT_RX = 28;
    localparam int CH_VIT_TX = 29;
    localparam int CH_TURBO_RX = 30;
    localparam int CH_TURBO_TX = 31;
    localparam int CH_CELL_RX = 32;
    localparam int CH_CELL_TX = 40;
    localparam int CH_PIN8 = 48;
    // Reset values
    localparam logic [63:0] RST_PEND = 64'h0;
    localparam logic [63:0] RST_EN = 64'h0;
    localparam logic [1:0] RST_STS = 2'h0;
    localparam logic [1:0] RST_MASK = 2'h0;
endpackage

// file: design/dcem_top.sv
// Channel event map: fixed event-to-channel wiring, pending latch, trigger issue
//
// How it works
// [RULE_01] Sixty-four channels, each wired to one fixed event, not software-assignable.
// [RULE_02] Events latch into pending even when that channel's enable bit is clear.
// [RULE_03] Each channel's priority comes from its own parameter memory entry.
// [RULE_04] Channel 0 fires on the host-port or bus-interface processor interrupt.
// [RULE_05] Channel 3 fires on the wide memory interface's SDRAM refresh event.
// [RULE_06] Channel 20 fires on the narrow memory interface's SDRAM refresh event.
// [RULE_07] Channels 4 to 7 fire on combined pin events 4 to 7.
// [RULE_08] Channels 12 to 15 fire on serial ports 0 and 1 transmit, receive.
// [RULE_09] Channels 17 and 18 fire on serial port 2 transmit and receive.
// [RULE_10] Channels 28 and 29 fire on Viterbi receive and transmit events.
// [RULE_11] Channels 30 and 31 fire on turbo receive and transmit events.
// [RULE_12] Channel 32 fires on cell receive, channel 40 on cell transmit.
// [RULE_13] Channel 21 is reserved with no event source connected.
// [RULE_14] Every channel also accepts chaining completion events from the transfer engine.
// [RULE_15] Without bus and cell interfaces, their events are never asserted.
// [RULE_16] Without decoding coprocessors, Viterbi and turbo events are never asserted.
// [RULE_17] Channels 1, 2 and 19 fire on timer 0, 1, 2 interrupts.
// [RULE_18] Channels 8-11 fire on pin events 0-3; 48-55 on pin events 8-15.
// [RULE_19] Channels 16, 22-27, 33-39, 41-47, 56-63 have inputs tied inactive.
`timescale 1ns/1ps
module dcem_top
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic has_bus_cell,
    input wire logic has_coproc,
    input wire logic host_port_evt,
    input wire logic bus_if_evt,
    input wire logic timer0_irq,
    input wire logic timer1_irq,
    input wire logic timer2_irq,
    input wire logic wide_sdram_refresh_evt,
    input wire logic narrow_sdram_refresh_evt,
    input wire logic pin0_evt,
    input wire logic pin1_evt,
    input wire logic pin2_evt,
    input wire logic pin3_evt,
    input wire logic pin4_combined_evt,
    input wire logic pin5_combined_evt,
    input wire logic pin6_combined_evt,
    input wire logic pin7_combined_evt,
    input wire logic [7:0] pin_hi_evt,
    input wire logic serial0_tx_evt,
    input wire logic serial0_rx_evt,
    input wire logic serial1_tx_evt,
    input wire logic serial1_rx_evt,
    input wire logic serial2_tx_evt,
    input wire logic serial2_rx_evt,
    input wire logic viterbi_rx_evt,
    input wire logic viterbi_tx_evt,
    input wire logic turbo_rx_evt,
    input wire logic turbo_tx_evt,
    input wire logic cell_rx_evt,
    input wire logic cell_tx_evt,
    input wire logic [63:0] chain_evt,
    output logic trig_valid,
    output logic [5:0] trig_chan,
    output logic trig_urgent,
    input wire logic trig_ready,
    output logic irq
);

    // Address match, shared by the read and write decoders
    function automatic logic dcem_hit(input logic [11:0] a, input logic [11:0] off);
        dcem_hit = (a[11:2] == off[11:2]);
    endfunction

    // Lowest-numbered set bit, with a found flag in the top bit
    function automatic logic [6:0] dcem_first(input logic [63:0] v);
        logic [6:0] r;
        r = 7'h00;
        for (int i = 63; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = {1'b1, i[5:0]};
            end
        end
        dcem_first = r;
    endfunction

    logic [63:0] raw_evt;
    logic [63:0] evt_q;
    logic [63:0] evt_prev_q;
    logic [63:0] evt_rise;
    logic [63:0] pend_q;
    logic [63:0] pend_d;
    logic [63:0] en_q;
    logic [63:0] sw_set;
    logic [63:0] sw_clr;
    logic [63:0] issue_clr;
    logic [63:0] cand;
    logic [63:0] urgent_vec;
    logic param_urgent_q [64];
    logic buscell_q;
    logic coproc_q;
    logic [1:0] sts_q;
    logic [1:0] sts_d;
    logic [1:0] mask_q;
    logic [1:0] sts_evt;
    logic [6:0] pick_urgent;
    logic [6:0] pick_any;
    logic [6:0] pick;
    logic can_load;
    logic load;
    logic apb_setup;
    logic apb_wr;
    logic [31:0] rd_d;
    logic rd_err;
    logic [5:0] param_idx;
    logic param_hit;
    logic trig_valid_q;
    logic [5:0] trig_chan_q;
    logic trig_urgent_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;

    // Variant straps held in flops; reset leaves both peripherals absent
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            buscell_q <= 1'b0;
            coproc_q <= 1'b0;
        end
        else
        begin
            buscell_q <= has_bus_cell;
            coproc_q <= has_coproc;
        end
    end

    // Fixed event wiring; no register can move an event to another channel
    always_comb
    begin
        raw_evt = 64'h0; // RULE_19
        raw_evt[dcem_pkg::CH_HOST] = host_port_evt | (buscell_q & bus_if_evt); // RULE_04
        raw_evt[dcem_pkg::CH_TMR0] = timer0_irq; // RULE_17
        raw_evt[dcem_pkg::CH_TMR1] = timer1_irq; // RULE_17
        raw_evt[dcem_pkg::CH_TMR2] = timer2_irq; // RULE_17
        raw_evt[dcem_pkg::CH_WIDE_REF] = wide_sdram_refresh_evt; // RULE_05
        raw_evt[dcem_pkg::CH_NARROW_REF] = narrow_sdram_refresh_evt; // RULE_06
        raw_evt[dcem_pkg::CH_PIN4] = pin4_combined_evt; // RULE_07
        raw_evt[dcem_pkg::CH_PIN4 + 1] = pin5_combined_evt; // RULE_07
        raw_evt[dcem_pkg::CH_PIN4 + 2] = pin6_combined_evt; // RULE_07
        raw_evt[dcem_pkg::CH_PIN4 + 3] = pin7_combined_evt; // RULE_07
        raw_evt[dcem_pkg::CH_PIN0] = pin0_evt; // RULE_18
        raw_evt[dcem_pkg::CH_PIN0 + 1] = pin1_evt; // RULE_18
        raw_evt[dcem_pkg::CH_PIN0 + 2] = pin2_evt; // RULE_18
        raw_evt[dcem_pkg::CH_PIN0 + 3] = pin3_evt; // RULE_18
        raw_evt[dcem_pkg::CH_PIN8 +: 8] = pin_hi_evt; // RULE_18
        raw_evt[dcem_pkg::CH_SER0_TX] = serial0_tx_evt; // RULE_08
        raw_evt[dcem_pkg::CH_SER0_RX] = serial0_rx_evt; // RULE_08
        raw_evt[dcem_pkg::CH_SER1_TX] = serial1_tx_evt; // RULE_08
        raw_evt[dcem_pkg::CH_SER1_RX] = serial1_rx_evt; // RULE_08
        raw_evt[dcem_pkg::CH_SER2_TX] = serial2_tx_evt; // RULE_09
        raw_evt[dcem_pkg::CH_SER2_RX] = serial2_rx_evt; // RULE_09
        // Coprocessor and cell events gated off on variants that lack them
        raw_evt[dcem_pkg::CH_VIT_RX] = coproc_q & viterbi_rx_evt; // RULE_10 RULE_16
        raw_evt[dcem_pkg::CH_VIT_TX] = coproc_q & viterbi_tx_evt; // RULE_10 RULE_16
        raw_evt[dcem_pkg::CH_TURBO_RX] = coproc_q & turbo_rx_evt; // RULE_11 RULE_16
        raw_evt[dcem_pkg::CH_TURBO_TX] = coproc_q & turbo_tx_evt; // RULE_11 RULE_16
        raw_evt[dcem_pkg::CH_CELL_RX] = buscell_q & cell_rx_evt; // RULE_12 RULE_15
        raw_evt[dcem_pkg::CH_CELL_TX] = buscell_q & cell_tx_evt; // RULE_12 RULE_15
        raw_evt[dcem_pkg::CH_RESERVED] = 1'b0; // RULE_13
    end

    // Event sampling; a held level counts once, at its rising edge
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            evt_q <= 64'h0;
            evt_prev_q <= 64'h0;
        end
        else
        begin
            evt_q <= raw_evt; // RULE_01
            evt_prev_q <= evt_q;
        end
    end

    assign evt_rise = evt_q & ~evt_prev_q;

    // APB phases: answer is always one access cycle, no wait states
    assign apb_setup = psel & ~penable;
    assign apb_wr = psel & penable & pready_q & pwrite;
    assign param_hit = (paddr >= dcem_pkg::OFF_PARAM_BASE) && (paddr <= dcem_pkg::OFF_PARAM_LAST);
    assign param_idx = paddr[7:2];

    // Software strobes for pending set and write-one-to-clear
    always_comb
    begin
        sw_set = 64'h0;
        sw_clr = 64'h0;
        if (apb_wr && dcem_hit(paddr, dcem_pkg::OFF_SET_LO))
        begin
            sw_set[31:0] = pwdata;
        end
        if (apb_wr && dcem_hit(paddr, dcem_pkg::OFF_SET_HI))
        begin
            sw_set[63:32] = pwdata;
        end
        if (apb_wr && dcem_hit(paddr, dcem_pkg::OFF_PEND_LO))
        begin
            sw_clr[31:0] = pwdata;
        end
        if (apb_wr && dcem_hit(paddr, dcem_pkg::OFF_PEND_HI))
        begin
            sw_clr[63:32] = pwdata;
        end
    end

    // Trigger selection: urgent pending channels first, then lowest index
    always_comb
    begin
        for (int i = 0; i < 64; i++)
        begin
            urgent_vec[i] = param_urgent_q[i]; // RULE_03
        end
    end
    assign cand = pend_q & en_q;
    assign pick_urgent = dcem_first(cand & urgent_vec); // RULE_03
    assign pick_any = dcem_first(cand);
    assign pick = pick_urgent[6] ? pick_urgent : pick_any;
    assign can_load = ~trig_valid_q | trig_ready;
    assign load = can_load & pick[6];

    always_comb
    begin
        issue_clr = 64'h0;
        if (load)
        begin
            issue_clr[pick[5:0]] = 1'b1;
        end
    end

    // Pending latch ignores the enable; a new event beats a same-cycle clear
    assign pend_d = (pend_q & ~(sw_clr | issue_clr)) | evt_rise | chain_evt | sw_set; // RULE_02 RULE_14

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pend_q <= dcem_pkg::RST_PEND;
        end
        else
        begin
            pend_q <= pend_d; // RULE_02
        end
    end

    // Enable registers, only gate issue and never the latch
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            en_q <= dcem_pkg::RST_EN;
        end
        else if (apb_wr && dcem_hit(paddr, dcem_pkg::OFF_EN_LO))
        begin
            en_q[31:0] <= pwdata;
        end
        else if (apb_wr && dcem_hit(paddr, dcem_pkg::OFF_EN_HI))
        begin
            en_q[63:32] <= pwdata;
        end
    end

    // Per-channel parameter priority entries, one independent bit each
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < 64; i++)
            begin
                param_urgent_q[i] <= 1'b0;
            end
        end
        else if (apb_wr && param_hit)
        begin
            param_urgent_q[param_idx] <= pwdata[0]; // RULE_03
        end
    end

    // Trigger output held until the transfer engine takes it
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            trig_valid_q <= 1'b0;
            trig_chan_q <= 6'h00;
            trig_urgent_q <= 1'b0;
        end
        else if (can_load)
        begin
            trig_valid_q <= pick[6];
            trig_chan_q <= pick[5:0];
            trig_urgent_q <= pick_urgent[6]; // RULE_03
        end
    end

    // Sticky interrupt status; events win over a write-one clear
    assign sts_evt[dcem_pkg::STS_OVERRUN] = |((evt_rise | chain_evt) & pend_q);
    assign sts_evt[dcem_pkg::STS_ISSUED] = load;
    always_comb
    begin
        sts_d = sts_q;
        if (apb_wr && dcem_hit(paddr, dcem_pkg::OFF_IRQ_STS))
        begin
            sts_d = sts_q & ~pwdata[1:0];
        end
        sts_d = sts_d | sts_evt;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sts_q <= dcem_pkg::RST_STS;
            mask_q <= dcem_pkg::RST_MASK;
            irq_q <= 1'b0;
        end
        else
        begin
            sts_q <= sts_d;
            if (apb_wr && dcem_hit(paddr, dcem_pkg::OFF_IRQ_MASK))
            begin
                mask_q <= pwdata[1:0];
            end
            irq_q <= |(sts_d & mask_q); // Mask change shows one cycle later
        end
    end

    // Read mux, unmapped addresses answer with an error and zero data
    always_comb
    begin
        rd_d = 32'h0;
        rd_err = 1'b0;
        if (dcem_hit(paddr, dcem_pkg::OFF_PEND_LO))
        begin
            rd_d = pend_q[31:0];
        end
        else if (dcem_hit(paddr, dcem_pkg::OFF_PEND_HI))
        begin
            rd_d = pend_q[63:32];
        end
        else if (dcem_hit(paddr, dcem_pkg::OFF_EN_LO))
        begin
            rd_d = en_q[31:0];
        end
        else if (dcem_hit(paddr, dcem_pkg::OFF_EN_HI))
        begin
            rd_d = en_q[63:32];
        end
        else if (dcem_hit(paddr, dcem_pkg::OFF_SET_LO) || dcem_hit(paddr, dcem_pkg::OFF_SET_HI))
        begin
            rd_d = 32'h0;
        end
        else if (dcem_hit(paddr, dcem_pkg::OFF_IRQ_STS))
        begin
            rd_d[1:0] = sts_q;
        end
        else if (dcem_hit(paddr, dcem_pkg::OFF_IRQ_MASK))
        begin
            rd_d[1:0] = mask_q;
        end
        else if (dcem_hit(paddr, dcem_pkg::OFF_STATE))
        begin
            rd_d[dcem_pkg::ST_BUSCELL] = buscell_q;
            rd_d[dcem_pkg::ST_COPROC] = coproc_q;
            rd_d[dcem_pkg::ST_TVALID] = trig_valid_q;
            rd_d[dcem_pkg::ST_TCHAN_LSB +: 6] = trig_chan_q;
        end
        else if (param_hit)
        begin
            rd_d[0] = param_urgent_q[param_idx];
        end
        else
        begin
            rd_err = 1'b1;
        end
    end

    // APB answer registered in the setup cycle, shown for one access cycle
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= apb_setup;
            pslverr_q <= apb_setup & rd_err;
            prdata_q <= (apb_setup & ~pwrite) ? rd_d : 32'h0;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign trig_valid = trig_valid_q;
    assign trig_chan = trig_chan_q;
    assign trig_urgent = trig_urgent_q;
    assign irq = irq_q;

    // Checks on the mapping, latch and issue paths
    default clocking dcem_cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_latch_while_off: assert property (evt_rise[dcem_pkg::CH_PIN4] && !en_q[dcem_pkg::CH_PIN4] |=> pend_q[dcem_pkg::CH_PIN4]) // RULE_02
        else $error("event lost while channel disabled");
    a_wide_ref_map: assert property ($rose(wide_sdram_refresh_evt) |-> ##2 pend_q[dcem_pkg::CH_WIDE_REF]) // RULE_05
        else $error("wide refresh did not reach channel 3");
    a_narrow_ref_map: assert property ($rose(narrow_sdram_refresh_evt) |-> ##2 pend_q[dcem_pkg::CH_NARROW_REF]) // RULE_06
        else $error("narrow refresh did not reach channel 20");
    a_serial_tx_map: assert property ($rose(serial0_tx_evt) |-> ##2 pend_q[dcem_pkg::CH_SER0_TX]) // RULE_08
        else $error("serial 0 transmit did not reach channel 12");
    a_reserved_quiet: assert property (!evt_q[dcem_pkg::CH_RESERVED]) // RULE_13
        else $error("reserved channel saw a peripheral event");
    a_chain_sets: assert property (chain_evt[dcem_pkg::CH_RESERVED] |=> pend_q[dcem_pkg::CH_RESERVED]) // RULE_14
        else $error("chaining event not latched");
    a_cell_gated: assert property (!buscell_q |-> !raw_evt[dcem_pkg::CH_CELL_RX] && !raw_evt[dcem_pkg::CH_CELL_TX]) // RULE_15
        else $error("cell event on variant without it");
    a_coproc_gated: assert property (!coproc_q |-> raw_evt[31:28] == 4'h0) // RULE_16
        else $error("coprocessor event on variant without it");
    a_prio_source: assert property (load |=> trig_urgent_q == $past(urgent_vec[pick[5:0]])) // RULE_03
        else $error("trigger priority not from parameter entry");
    a_issue_enabled: assert property ($rose(trig_valid_q) |-> $past(en_q[pick[5:0]]) && !pend_q[trig_chan_q] || $past(pend_d[pick[5:0]])) // RULE_01
        else $error("trigger for disabled channel");

    c_trig_taken: cover property (trig_valid_q && trig_ready);
    c_latch_disabled: cover property (evt_rise[dcem_pkg::CH_PIN4] && !en_q[dcem_pkg::CH_PIN4]);
    c_irq_raise: cover property ($rose(irq_q));
endmodule

// file: verification/dcem_periph_model.sv
// Peripheral stand-in: a one-cycle event pulse on the source wired to a chosen channel
`timescale 1ns/1ps
module dcem_periph_model
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic fire,
    input wire logic [5:0] fire_ch,
    output logic [63:0] ev
);
    logic [63:0] ev_q;

    // High for one cycle only, so every request is a fresh rising event
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            ev_q <= 64'h0;
        else
            ev_q <= fire ? (64'h1 << fire_ch) : 64'h0;
    end

    // One slot per channel; the bench wires each sourced slot to its source pin, and slot 21 to the bus interface event
    assign ev = ev_q;
endmodule

// file: verification/dcem_bench.sv
// Self-checking bench for the channel event map: registers, event map, trigger issue
`timescale 1ns/1ps
module dcem_bench;
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, has_bus_cell, has_coproc;
    logic trig_valid, trig_urgent, trig_ready, irq, fire, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [63:0] chain_evt, want, ev;
    logic [5:0] trig_chan, fire_ch;
    int mismatches, n_checks;
    // Channels that own a peripheral source
    localparam logic [63:0] SRC_MAP = 64'h00FF0101_F01EFFFF;

    // Slot 21 has no source of its own, so it carries the bus interface event
    dcem_top dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .has_bus_cell(has_bus_cell), .has_coproc(has_coproc),
        .host_port_evt(ev[0]), .bus_if_evt(ev[21]), .timer0_irq(ev[1]), .timer1_irq(ev[2]),
        .timer2_irq(ev[19]), .wide_sdram_refresh_evt(ev[3]), .narrow_sdram_refresh_evt(ev[20]),
        .pin0_evt(ev[8]), .pin1_evt(ev[9]), .pin2_evt(ev[10]), .pin3_evt(ev[11]),
        .pin4_combined_evt(ev[4]), .pin5_combined_evt(ev[5]), .pin6_combined_evt(ev[6]),
        .pin7_combined_evt(ev[7]), .pin_hi_evt(ev[55:48]), .serial0_tx_evt(ev[12]),
        .serial0_rx_evt(ev[13]), .serial1_tx_evt(ev[14]), .serial1_rx_evt(ev[15]),
        .serial2_tx_evt(ev[17]), .serial2_rx_evt(ev[18]), .viterbi_rx_evt(ev[28]),
        .viterbi_tx_evt(ev[29]), .turbo_rx_evt(ev[30]), .turbo_tx_evt(ev[31]),
        .cell_rx_evt(ev[32]), .cell_tx_evt(ev[40]), .chain_evt(chain_evt),
        .trig_valid(trig_valid), .trig_chan(trig_chan), .trig_urgent(trig_urgent),
        .trig_ready(trig_ready), .irq(irq));

    dcem_periph_model periph (.clk(clk), .sys_rst(sys_rst), .fire(fire), .fire_ch(fire_ch),
        .ev(ev));

    // Free-running 200 MHz clock
    always #2.5 clk = ~clk;

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One transfer; an idle cycle after it keeps two assignments out of one time step
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'h1 && n < 20);
        check({31'h0, pready}, 32'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask

    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        check(rd, exp);
    endtask

    task pulse(input int ch);
        fire <= 1'h1;
        fire_ch <= ch[5:0];
        @(posedge clk);
        fire <= 1'h0;
        repeat (5) @(posedge clk);
    endtask

    // Fire one source, compare the whole pending pair, then clear it
    task fire_chk(input int ch, input logic [63:0] exp);
        pulse(ch);
        rdchk(dcem_pkg::OFF_PEND_LO, exp[31:0]);
        rdchk(dcem_pkg::OFF_PEND_HI, exp[63:32]);
        apb(1'h1, dcem_pkg::OFF_PEND_LO, 32'hFFFFFFFF);
        apb(1'h1, dcem_pkg::OFF_PEND_HI, 32'hFFFFFFFF);
    endtask

    // Wait for a trigger, compare it, accept it for one cycle
    task take(input logic [5:0] ch, input logic urg);
        int n;
        n = 0;
        while (trig_valid !== 1'h1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        check({26'h0, trig_chan}, {26'h0, ch});
        check({31'h0, trig_urgent}, {31'h0, urg});
        trig_ready <= 1'h1;
        @(posedge clk);
        trig_ready <= 1'h0;
        @(posedge clk);
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        {clk, psel, penable, pwrite, trig_ready, fire} = 6'h0;
        {paddr, pwdata, chain_evt, fire_ch} = 114'h0;
        {sys_rst, has_bus_cell, has_coproc} = 3'h7;
        mismatches = 0;
        n_checks = 0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'h0;
        @(posedge clk);
        for (int i = 0; i < 8; i++)
            rdchk(12'(4 * i), 32'h0);
        check({31'h0, trig_valid}, 32'h0);
        apb(1'h0, 12'h040, 32'h0);
        check({31'h0, er}, 32'h1);
        check(rd, 32'h0);
        rdchk(dcem_pkg::OFF_STATE, 32'h3);
        $display("test reset done");
        for (int ch = 0; ch < 64; ch++)
        begin
            want = (ch == 21) ? 64'h1 : (SRC_MAP[ch] ? (64'h1 << ch) : 64'h0);
            fire_chk(ch, want);
            check({31'h0, trig_valid}, 32'h0);
        end
        $display("test map done");
        has_bus_cell <= 1'h0;
        has_coproc <= 1'h0;
        repeat (3) @(posedge clk);
        rdchk(dcem_pkg::OFF_STATE, 32'h0);
        for (int ch = 0; ch < 64; ch++)
            if (ch == 21 || (ch >= 28 && ch <= 32) || ch == 40)
                fire_chk(ch, 64'h0);
        fire_chk(0, 64'h1);
        has_bus_cell <= 1'h1;
        has_coproc <= 1'h1;
        $display("test variants done");
        chain_evt <= 64'h80000000_00210000;
        @(posedge clk);
        chain_evt <= 64'h0;
        repeat (4) @(posedge clk);
        rdchk(dcem_pkg::OFF_PEND_LO, 32'h00210000);
        rdchk(dcem_pkg::OFF_PEND_HI, 32'h80000000);
        apb(1'h1, dcem_pkg::OFF_PEND_LO, 32'hFFFFFFFF);
        apb(1'h1, dcem_pkg::OFF_PEND_HI, 32'hFFFFFFFF);
        $display("test chaining done");
        apb(1'h1, dcem_pkg::OFF_PARAM_BASE + 12'h0A0, 32'h1);
        rdchk(dcem_pkg::OFF_PARAM_BASE + 12'h0A0, 32'h1);
        apb(1'h1, dcem_pkg::OFF_SET_LO, 32'h00000220);
        apb(1'h1, dcem_pkg::OFF_SET_HI, 32'h00000100);
        pulse(9);
        rdchk(dcem_pkg::OFF_IRQ_STS, 32'h1);
        rdchk(dcem_pkg::OFF_PEND_LO, 32'h00000220);
        for (int m = 2; m < 4; m++)
        begin
            apb(1'h1, dcem_pkg::OFF_IRQ_MASK, 32'(m));
            repeat (3) @(posedge clk);
            check({31'h0, irq}, 32'(m - 2));
        end
        apb(1'h1, dcem_pkg::OFF_IRQ_STS, 32'h1);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        apb(1'h1, dcem_pkg::OFF_EN_LO, 32'hFFFFFFFF);
        apb(1'h1, dcem_pkg::OFF_EN_HI, 32'hFFFFFFFF);
        take(6'h05, 1'h0);
        take(6'h28, 1'h1);
        take(6'h09, 1'h0);
        rdchk(dcem_pkg::OFF_IRQ_STS, 32'h2);
        check({31'h0, irq}, 32'h1);
        rdchk(dcem_pkg::OFF_PEND_LO, 32'h0);
        $display("test trigger done");
        give_verdict;
    end

    // Watchdog well beyond the roughly 1,500 cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        give_verdict;
    end
endmodule
